// file: verilog/pirq_regs.svh
/*
 * register offsets, field positions, reset values for the peripheral
 * interrupt flag block. assumes inclusion by bare name from design files.
 */
`ifndef PIRQ_REGS_SVH
`define PIRQ_REGS_SVH

// register offsets
`define PIRQ_OFS_FLAGS 8'h0C
`define PIRQ_OFS_ENABLES 8'h8C
`define PIRQ_OFS_CONTROL 8'h0B
`define PIRQ_OFS_STATUS 8'h40
`define PIRQ_OFS_CLEAR 8'h41
`define PIRQ_OFS_EVENT_EN 8'h42

// bit positions in the flag and enable registers
`define PIRQ_BIT_ADC 6
`define PIRQ_BIT_SSP 3
`define PIRQ_BIT_CCP 2
`define PIRQ_BIT_PER 1
`define PIRQ_BIT_OVF 0

// implemented bits mask
`define PIRQ_IMPL_MASK 8'h4F

// control register bits
`define PIRQ_BIT_PGATE 6
`define PIRQ_BIT_GGATE 7

// reset values
`define PIRQ_RST_FLAGS 8'h00
`define PIRQ_RST_ENABLES 8'h00
`define PIRQ_RST_CONTROL 8'h00

`endif

// file: verilog/pirq_pkg.sv
/*
 * types shared by the flag block files.
 * assumes nothing of its surroundings.
 */
package pirq_pkg;
   // register data byte
   typedef logic [7:0] pirq_byte_t;
   // capture/compare unit operating mode
   typedef enum logic [1:0] {
      pirq_ccp_off,
      pirq_ccp_capture,
      pirq_ccp_compare,
      pirq_ccp_pwm
   } pirq_ccp_mode_e;
endpackage

// file: verilog/pirq_evt_if.sv
/*
 * interface carrying the qualified set requests from the event
 * qualifier to the flag register. assumes one clock domain.
 */
`timescale 1ns/1ns
interface pirq_evt_if;
   import pirq_pkg::*;
   // one bit per flag, one-cycle set pulses
   pirq_byte_t set_req;
   modport src (output set_req);
   modport dst (input set_req);
endinterface

// file: verilog/pirq_evt_qual.sv
/*
 * event qualifier: turns raw peripheral events into flag set requests.
 * assumes event inputs are pulses on clk_sys.
 */
`timescale 1ns/1ns
`include "pirq_regs.svh"
module pirq_evt_qual (
   // clock and reset
   input wire logic clk_sys,
   input wire logic nrst,
   // raw events
   input wire logic adc_done,
   input wire logic ssp_done,
   input wire logic ccp_capture,
   input wire logic ccp_match,
   input wire pirq_pkg::pirq_ccp_mode_e ccp_mode,
   input wire logic period_match,
   input wire logic wide_overflow,
   // qualified requests
   pirq_evt_if.src evt
);
   import pirq_pkg::*;

   // capture/compare event by mode
   logic ccp_evt;

   // select capture/compare source by mode
   always_comb begin
      ccp_evt = 1'b0;
      unique case (ccp_mode)
         pirq_ccp_capture: begin
            ccp_evt = ccp_capture;
         end
         pirq_ccp_compare: begin
            ccp_evt = ccp_match;
         end
         pirq_ccp_pwm: begin
            ccp_evt = 1'b0;
         end
         pirq_ccp_off: begin
            ccp_evt = 1'b0;
         end
      endcase
   end

   // assemble per-bit set requests
   always_comb begin
      evt.set_req = 8'h00;
      evt.set_req[`PIRQ_BIT_ADC] = adc_done;
      evt.set_req[`PIRQ_BIT_SSP] = ssp_done;
      evt.set_req[`PIRQ_BIT_CCP] = ccp_evt;
      evt.set_req[`PIRQ_BIT_PER] = period_match;
      evt.set_req[`PIRQ_BIT_OVF] = wide_overflow;
   end
endmodule

// file: verilog/pirq_flags.sv
/*
 * peripheral interrupt flag register with enables, gate control and a
 * small event-status block, on a plain register port.
 * assumes event pulses arrive synchronous to clk_sys.
 */
// Behaviour
// - bits 7,5,4 read zero, ignore writes
// - conversion done sets bit 6
// - serial transfer done sets bit 3
// - capture sets capture/compare flag bit 2
// - compare match sets bit 2
// - pwm mode never sets bit 2
// - period match sets bit 1
// - wide timer rollover sets bit 0
// - flags sticky until software writes zero
// - flags set regardless of enables
// - each flag gated by own enable
// - peripheral gate must enable requests
`timescale 1ns/1ns
`include "pirq_regs.svh"
module pirq_flags (
   // clock and reset
   input wire logic clk_sys,
   input wire logic nrst,
   // register port
   input wire logic [7:0] reg_addr,
   input wire pirq_pkg::pirq_byte_t reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output pirq_pkg::pirq_byte_t reg_rdata,
   // peripheral events
   input wire logic adc_done,
   input wire logic ssp_done,
   input wire logic ccp_capture,
   input wire logic ccp_match,
   input wire pirq_pkg::pirq_ccp_mode_e ccp_mode,
   input wire logic period_match,
   input wire logic wide_overflow,
   // interrupt outputs
   output logic periph_irq,
   output logic block_irq
);
   import pirq_pkg::*;

   // flag register
   pirq_byte_t peripheral_flags_1;
   // enable register
   pirq_byte_t peripheral_enables_1;
   // control register gates
   logic peripheral_irq_gate;
   logic global_irq_gate;
   // block event status, enable
   pirq_byte_t evt_status;
   pirq_byte_t evt_enable;
   // next flag value
   pirq_byte_t next_flags;
   // set requests from qualifier
   pirq_evt_if evt ();

   // write decode helper
   function automatic logic wr_hit(input logic [7:0] a,
                                   input logic [7:0] ofs,
                                   input logic w);
      wr_hit = w && (a == ofs);
   endfunction

   // event qualification
   pirq_evt_qual u_qual (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .adc_done(adc_done),
      .ssp_done(ssp_done),
      .ccp_capture(ccp_capture),
      .ccp_match(ccp_match),
      .ccp_mode(ccp_mode),
      .period_match(period_match),
      .wide_overflow(wide_overflow),
      .evt(evt)
   );

   // next flag value from write and events
   always_comb begin
      next_flags = peripheral_flags_1;
      if (wr_hit(reg_addr, `PIRQ_OFS_FLAGS, reg_wr)) begin
         next_flags = reg_wdata;
      end
      next_flags = next_flags | evt.set_req;
      next_flags = next_flags & `PIRQ_IMPL_MASK;
   end

   // flag register update
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         peripheral_flags_1 <= `PIRQ_RST_FLAGS;
      end else begin
         peripheral_flags_1 <= next_flags;
      end
   end

   // enable register
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         peripheral_enables_1 <= `PIRQ_RST_ENABLES;
      end else if (wr_hit(reg_addr, `PIRQ_OFS_ENABLES, reg_wr)) begin
         peripheral_enables_1 <= reg_wdata & `PIRQ_IMPL_MASK;
      end
   end

   // control register gates
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         peripheral_irq_gate <= 1'b0;
         global_irq_gate <= 1'b0;
      end else if (wr_hit(reg_addr, `PIRQ_OFS_CONTROL, reg_wr)) begin
         peripheral_irq_gate <= reg_wdata[`PIRQ_BIT_PGATE];
         global_irq_gate <= reg_wdata[`PIRQ_BIT_GGATE];
      end
   end

   // block event status: sticky, write-one-to-clear, set wins
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         evt_status <= 8'h00;
      end else if (wr_hit(reg_addr, `PIRQ_OFS_CLEAR, reg_wr)) begin
         evt_status <= (evt_status & ~reg_wdata) | evt.set_req;
      end else begin
         evt_status <= evt_status | evt.set_req;
      end
   end

   // block event enable
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         evt_enable <= 8'h00;
      end else if (wr_hit(reg_addr, `PIRQ_OFS_EVENT_EN, reg_wr)) begin
         evt_enable <= reg_wdata & `PIRQ_IMPL_MASK;
      end
   end

   // processor interrupt request, registered
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         periph_irq <= 1'b0;
      end else begin
         periph_irq <= peripheral_irq_gate && global_irq_gate &&
                       (|(peripheral_flags_1 & peripheral_enables_1));
      end
   end

   // block level interrupt
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         block_irq <= 1'b0;
      end else begin
         block_irq <= |(evt_status & evt_enable);
      end
   end

   // read data, one cycle after read strobe
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         unique case (reg_addr)
            `PIRQ_OFS_FLAGS: begin
               reg_rdata <= peripheral_flags_1 & `PIRQ_IMPL_MASK;
            end
            `PIRQ_OFS_ENABLES: begin
               reg_rdata <= peripheral_enables_1;
            end
            `PIRQ_OFS_CONTROL: begin
               reg_rdata <= {global_irq_gate, peripheral_irq_gate, 6'h00};
            end
            `PIRQ_OFS_STATUS: begin
               reg_rdata <= evt_status;
            end
            `PIRQ_OFS_EVENT_EN: begin
               reg_rdata <= evt_enable;
            end
            // unmapped and write-only read zero
            default: begin
               reg_rdata <= 8'h00;
            end
         endcase
      end else begin
         reg_rdata <= 8'h00;
      end
   end
endmodule

// file: verif/pirq_flags_chk.sv
/* assertions on the flag block ports.
   assumes a bind onto pirq_flags. */
`timescale 1ns/1ns
module pirq_flags_chk import pirq_pkg::*; (
   // clock, reset
   input wire logic clk_sys,
   input wire logic nrst,
   // register port
   input wire logic [7:0] reg_addr,
   input wire pirq_pkg::pirq_byte_t reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire pirq_pkg::pirq_byte_t reg_rdata,
   // events
   input wire logic adc_done,
   input wire logic ssp_done,
   input wire logic ccp_capture,
   input wire logic ccp_match,
   input wire pirq_pkg::pirq_ccp_mode_e ccp_mode
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   // read of the flag register
   sequence rd_f;
      reg_rd && reg_addr == 8'h0C;
   endsequence
   a_unimpl_zero: assert property (rd_f |=> (reg_rdata & 8'hB0) == 0)
      else $error("unimplemented flag bits read nonzero");
   a_adc_sets: assert property (adc_done ##1 rd_f |=> reg_rdata[6])
      else $error("conversion flag not set");
   a_ssp_sets: assert property (ssp_done ##1 rd_f |=> reg_rdata[3])
      else $error("serial flag not set");
   a_cap_sets: assert property (
      (ccp_capture && ccp_mode == pirq_ccp_capture) ##1 rd_f |=> reg_rdata[2])
      else $error("capture flag not set");
   a_cmp_sets: assert property (
      (ccp_match && ccp_mode == pirq_ccp_compare) ##1 rd_f |=> reg_rdata[2])
      else $error("compare flag not set");
   a_flag_sticky: assert property (
      rd_f ##1 (reg_rdata[0] && !reg_wr) ##1 rd_f |=> reg_rdata[0])
      else $error("overflow flag dropped");
   a_write_one: assert property (
      (reg_wr && reg_addr == 8'h0C && reg_wdata[1]) ##1 !reg_wr ##1 rd_f
      |=> reg_rdata[1])
      else $error("written one not kept");
   a_pwm_quiet: assert property (
      (reg_rd && reg_addr == 8'h0C && ccp_mode == pirq_ccp_pwm)
      ##1 (!reg_rdata[2] && ccp_mode == pirq_ccp_pwm && !reg_wr)
      ##1 (ccp_mode == pirq_ccp_pwm && !reg_wr)[*2] ##1 rd_f
      |=> !reg_rdata[2])
      else $error("pwm mode set the flag");
endmodule

// file: verif/pirq_ev_model.sv
/* peripheral event sources: one-cycle event pulses on request.
   assumes the bench holds each request for one cycle. */
`timescale 1ns/1ns
module pirq_ev_model (
   // clock
   input wire logic clk_sys,
   // request: adc, ssp, cap, cmp, per, ovf
   input wire logic [5:0] fire,
   // event pulses
   output logic adc_done,
   output logic ssp_done,
   output logic ccp_capture,
   output logic ccp_match,
   output logic period_match,
   output logic wide_overflow
);
   // each request cycle is one event
   always_ff @(posedge clk_sys) begin
      {adc_done, ssp_done, ccp_capture, ccp_match, period_match,
         wide_overflow} <= fire;
   end
endmodule

// file: verif/testbench.sv
/* bench for the flag block: bus tasks, scenarios, verdict.
   assumes the model and checker files are compiled first. */
`timescale 1ns/1ns
module testbench;
   import pirq_pkg::*;
   // expected flag per event, adc first
   localparam logic [47:0] EXP = 48'h400804040201;
   logic clk_sys = 1'b0;
   logic nrst = 1'b0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   pirq_byte_t reg_wdata = 8'h00;
   pirq_byte_t reg_rdata;
   logic [5:0] fire = 6'h00;
   pirq_ccp_mode_e ccp_mode = pirq_ccp_capture;
   logic adc_done, ssp_done, ccp_capture, ccp_match;
   logic period_match, wide_overflow, periph_irq, block_irq;
   int mismatches = 0;
   int n_checks = 0;
   // clock
   initial forever #20 clk_sys = ~clk_sys;
   pirq_ev_model pirq_ev_model_i (.clk_sys(clk_sys), .fire(fire),
      .adc_done(adc_done), .ssp_done(ssp_done), .ccp_capture(ccp_capture),
      .ccp_match(ccp_match), .period_match(period_match),
      .wide_overflow(wide_overflow));
   pirq_flags pirq_flags_i (.clk_sys(clk_sys), .nrst(nrst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .adc_done(adc_done),
      .ssp_done(ssp_done), .ccp_capture(ccp_capture), .ccp_match(ccp_match),
      .ccp_mode(ccp_mode), .period_match(period_match),
      .wide_overflow(wide_overflow), .periph_irq(periph_irq),
      .block_irq(block_irq));
   // compare and count
   task chk(input string n, input logic [7:0] e, input logic [7:0] s);
      n_checks++;
      if (s !== e) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask
   // one write cycle
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask
   // one read cycle, data checked in the next
   task rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      @(negedge clk_sys);
      chk("rdata", e, reg_rdata);
   endtask
   // one event pulse
   task ev(input logic [5:0] m);
      @(posedge clk_sys);
      fire <= m;
      @(posedge clk_sys);
      fire <= 6'h00;
   endtask
   // interrupt lines after they settle
   task irq(input logic p, input logic b);
      repeat (3) @(negedge clk_sys);
      chk("periph_irq", {7'h00, p}, {7'h00, periph_irq});
      chk("block_irq", {7'h00, b}, {7'h00, block_irq});
   endtask
   // reset values, write mask, unmapped place
   task t_regs;
      rd(8'h0C, 8'h00);
      wr(8'h0C, 8'hFF);
      rd(8'h0C, 8'h4F);
      wr(8'h0C, 8'h00);
      rd(8'h0C, 8'h00);
      rd(8'h77, 8'h00);
   endtask
   // every source with enables off
   task t_events;
      for (int i = 0; i < 6; i++) begin
         ccp_mode <= (i == 2) ? pirq_ccp_capture : pirq_ccp_compare;
         ev(6'h20 >> i);
         rd(8'h0C, EXP[47-8*i -: 8]);
         wr(8'h0C, 8'h00);
      end
      ccp_mode <= pirq_ccp_pwm;
      rd(8'h0C, 8'h00);
      ev(6'h0C);
      rd(8'h0C, 8'h00);
      @(posedge clk_sys);
      ccp_mode <= pirq_ccp_off;
      ev(6'h0C);
      rd(8'h0C, 8'h00);
   endtask
   // flags stay until software clears, set beats clear
   task t_sticky;
      ev(6'h11);
      repeat (20) @(posedge clk_sys);
      rd(8'h0C, 8'h09);
      wr(8'h0C, 8'h01);
      rd(8'h0C, 8'h01);
      rd(8'h0C, 8'h01);
      @(posedge clk_sys);
      fire <= 6'h02;
      @(posedge clk_sys);
      fire <= 6'h00;
      reg_addr <= 8'h0C;
      reg_wdata <= 8'h00;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
      rd(8'h0C, 8'h02);
   endtask
   // enable, gate, and event status block
   task t_irq;
      wr(8'h41, 8'hFF);
      wr(8'h8C, 8'h02);
      rd(8'h8C, 8'h02);
      irq(1'b0, 1'b0);
      wr(8'h0B, 8'hC0);
      rd(8'h0B, 8'hC0);
      irq(1'b1, 1'b0);
      wr(8'h8C, 8'h01);
      irq(1'b0, 1'b0);
      wr(8'h42, 8'h01);
      ev(6'h01);
      irq(1'b1, 1'b1);
      rd(8'h40, 8'h01);
      wr(8'h41, 8'h01);
      irq(1'b1, 1'b0);
      rd(8'h40, 8'h00);
   endtask
   // verdict
   task stop_test;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // main sequence
   initial begin
      repeat (10) @(posedge clk_sys);
      nrst <= 1'b1;
      t_regs;
      t_events;
      t_sticky;
      t_irq;
      stop_test;
   end
   // watchdog, well past the expected run
   initial begin
      #80000;
      mismatches++;
      stop_test;
   end
endmodule
bind pirq_flags pirq_flags_chk pirq_flags_chk_i (.clk_sys(clk_sys),
   .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .adc_done(adc_done), .ssp_done(ssp_done), .ccp_capture(ccp_capture),
   .ccp_match(ccp_match), .ccp_mode(ccp_mode));
